// ---- psc_ctrl.sv ----
// priority control end: start, interrupt, counter and tester orders
`timescale 1ns/1ps
module psc_ctrl #(
  parameter int DIV = 4 // clocks per time pulse
) (
  input  wire logic                          clk,
  input  wire logic                          nrst,
  psc_if.dev                                 bus,
  input  wire logic                          power_ok_pin,
  input  wire logic                          alarm_pin,
  input  wire logic                          trap_pin,
  input  wire logic                          intr_fault_pin,
  input  wire logic                          mon_stop_pin,
  input  wire logic                          manual_start_pin,
  input  wire logic [psc_pkg::NUM_VECTORS-1:0] intr_req,
  input  wire logic [psc_pkg::NUM_COUNTERS-1:0] cnt_req,
  input  wire logic                          test_req,
  input  wire logic [1:0]                    test_kind,
  input  wire logic [11:0]                   test_addr,
  input  wire logic [15:0]                   test_wdata,
  output logic                               test_busy,
  output logic                               cnt_alarm,
  output logic [psc_pkg::NUM_VECTORS-1:0]    intr_pend
);
  localparam int NV = psc_pkg::NUM_VECTORS;
  localparam int NC = psc_pkg::NUM_COUNTERS;
  localparam int DW = $clog2(DIV);

  // pin synchronisers, two stages each
  logic [5:0] pin_s1_r; // first stage
  logic [5:0] pin_s2_r; // second stage
  always_ff @(posedge clk) begin
    if (!nrst) begin
      pin_s1_r <= 6'h01;
      pin_s2_r <= 6'h01;
    end else begin
      pin_s1_r <= {manual_start_pin, mon_stop_pin, intr_fault_pin, trap_pin,
                   alarm_pin, power_ok_pin};
      pin_s2_r <= pin_s1_r;
    end
  end
  logic power_ok, alarm, trap, intr_fault, mon_stop, manual_start;
  assign {manual_start, mon_stop, intr_fault, trap, alarm, power_ok} = pin_s2_r;

  // time pulse enable divider
  logic [DW-1:0] div_r; // divider count
  logic          tick;  // one-cycle time pulse enable
  always_ff @(posedge clk) begin
    if (!nrst) begin
      div_r <= '0;
    end else if (div_r == DW'(DIV - 1)) begin
      div_r <= '0;
    end else begin
      div_r <= div_r + DW'(1);
    end
  end
  assign tick = (div_r == DW'(DIV - 1));

  // start state machine
  typedef enum logic [1:0] {
    PSC_S_RUN   = 2'b00,
    PSC_S_RESET = 2'b01,
    PSC_S_FORCE = 2'b10
  } psc_start_t;
  psc_start_t start_r;                 // start sequence state
  logic [2:0] hold_r;                  // time pulses of reset hold
  logic       start_cause;             // any reason to initialize
  logic       cycle_end;               // end of a memory cycle
  logic       stop;                    // stop to the timer

  // fault, trap, power glitch, interrupt fault or manual start
  assign start_cause = !power_ok || alarm || trap || intr_fault
                       || (mon_stop && manual_start);
  // the stop covers start sequence and monitor stop
  assign stop = (start_r != PSC_S_RUN) || mon_stop || start_cause;

  always_ff @(posedge clk) begin
    if (!nrst) begin
      start_r <= PSC_S_RESET;
      hold_r  <= '0;
    end else begin
      case (start_r)
        PSC_S_RUN: begin
          if (start_cause) begin
            start_r <= PSC_S_RESET;
            hold_r  <= '0;
          end
        end
        PSC_S_RESET: begin
          // essential resets take a few time pulses
          if (start_cause) begin
            hold_r <= '0;
          end else if (tick && hold_r != 3'(psc_pkg::RESET_HOLD)) begin
            hold_r <= hold_r + 3'h1;
          end else if (hold_r == 3'(psc_pkg::RESET_HOLD)) begin
            start_r <= PSC_S_FORCE;
          end
        end
        PSC_S_FORCE: begin
          if (bus.start_done) begin
            start_r <= PSC_S_RUN;
          end
        end
        default: start_r <= PSC_S_RESET;
      endcase
    end
  end

  psc_timer u_timer (
    .clk       (clk),
    .nrst      (nrst),
    .tick      (tick),
    .stop      (stop),
    .pulse     (bus.time_pulse),
    .cycle_end (cycle_end)
  );
  assign bus.cycle_end    = cycle_end;
  assign bus.tpg_stop     = stop;
  assign bus.fresh_start  = (start_r == PSC_S_RESET);
  assign bus.monitor_stop = mon_stop;

  // pending interrupts, set wins over clear
  logic [NV-1:0] pend_r;     // latched requests
  logic [NV-1:0] take_vec;   // vector being taken
  logic          intr_sel;   // interrupt currently forced
  logic [3:0]    intr_idx_r; // selected vector index
  genvar gi;
  generate
    for (gi = 0; gi < NV; gi++) begin : g_pend
      assign take_vec[gi] = intr_sel && bus.read_pulse && (intr_idx_r == 4'(gi))
                            && bus.addr_valid
                            && bus.decoded_addr == 12'(psc_pkg::VEC_BASE
                               + 12'(gi) * psc_pkg::VEC_STEP);
      always_ff @(posedge clk) begin
        if (!nrst || bus.fresh_start) begin
          pend_r[gi] <= 1'b0;
        end else if (intr_req[gi]) begin
          pend_r[gi] <= 1'b1;
        end else if (take_vec[gi]) begin
          pend_r[gi] <= 1'b0;
        end
      end
    end
  endgenerate
  assign intr_pend = pend_r;

  // fixed priority, lowest index first
  logic [3:0] intr_pick;
  logic       intr_any;
  always_comb begin
    intr_pick = 4'h0;
    intr_any  = 1'b0;
    for (int i = NV - 1; i >= 0; i--) begin
      if (pend_r[i]) begin
        intr_pick = 4'(i);
        intr_any  = 1'b1;
      end
    end
  end

  // counter requests held pending, 29 addresses with priority
  logic [NC-1:0] cpend_r;
  logic [4:0]    cnt_pick;
  logic          cnt_any;
  logic [4:0]    cnt_idx_r;
  logic          cnt_sel;
  always_comb begin
    cnt_pick = 5'h0;
    cnt_any  = 1'b0;
    for (int i = NC - 1; i >= 0; i--) begin
      if (cpend_r[i]) begin
        cnt_pick = 5'(i);
        cnt_any  = 1'b1;
      end
    end
  end
  always_ff @(posedge clk) begin
    if (!nrst || bus.fresh_start) begin
      cpend_r <= '0;
    end else begin
      for (int i = 0; i < NC; i++) begin
        if (cnt_req[i]) begin
          cpend_r[i] <= 1'b1;
        end else if (cnt_sel && bus.read_pulse && cnt_idx_r == 5'(i)) begin
          cpend_r[i] <= 1'b0;
        end
      end
    end
  end

  // alarm when the top counter request waits too long
  logic [3:0] wait_r;
  always_ff @(posedge clk) begin
    if (!nrst || bus.fresh_start) begin
      wait_r    <= '0;
      cnt_alarm <= 1'b0;
    end else if (!cnt_any || (cnt_sel && bus.read_pulse)) begin
      wait_r <= '0;
    end else if (cycle_end) begin
      if (wait_r == 4'(psc_pkg::ALARM_CYCLES)) begin
        cnt_alarm <= 1'b1;
      end else begin
        wait_r <= wait_r + 4'h1;
      end
    end
  end

  // forced order selection in any clock cycle of run in which no order stands
  psc_pkg::psc_order_t ord_r;
  logic [11:0]         addr_r;
  logic [15:0]         tdata_r;
  logic [1:0]          top_r;
  assign intr_sel = (ord_r == psc_pkg::PSC_ORD_INTR);
  assign cnt_sel  = (ord_r == psc_pkg::PSC_ORD_CNT);
  always_ff @(posedge clk) begin
    if (!nrst) begin
      ord_r      <= psc_pkg::PSC_ORD_NONE;
      addr_r     <= '0;
      tdata_r    <= '0;
      top_r      <= psc_pkg::PSC_TOP_NONE;
      intr_idx_r <= '0;
      cnt_idx_r  <= '0;
    end else if (start_r == PSC_S_FORCE) begin
      // withdraw once read, else the start order stands on into run and
      // the sequencer, already pulsed for it, never takes another order
      if (bus.read_pulse) begin
        ord_r <= psc_pkg::PSC_ORD_NONE;
      end else begin
        ord_r  <= psc_pkg::PSC_ORD_START;
        addr_r <= psc_pkg::START_ADDR;
      end
    end else if (start_r != PSC_S_RUN) begin
      ord_r <= psc_pkg::PSC_ORD_NONE;
    end else if (ord_r != psc_pkg::PSC_ORD_NONE) begin
      if (bus.read_pulse) begin
        ord_r <= psc_pkg::PSC_ORD_NONE;
        top_r <= psc_pkg::PSC_TOP_NONE;
      end
    end else if (mon_stop) begin
      // tester orders only while program is halted
      if (test_req && !bus.program_run) begin
        ord_r   <= psc_pkg::PSC_ORD_TEST;
        addr_r  <= test_addr;
        tdata_r <= test_wdata;
        top_r   <= test_kind;
      end
    end else if (cnt_any) begin
      ord_r     <= psc_pkg::PSC_ORD_CNT;
      addr_r    <= psc_pkg::CNT_BASE + 12'(cnt_pick);
      cnt_idx_r <= cnt_pick;
    end else if (intr_any) begin
      ord_r      <= psc_pkg::PSC_ORD_INTR;
      addr_r     <= 12'(psc_pkg::VEC_BASE + 12'(intr_pick) * psc_pkg::VEC_STEP);
      intr_idx_r <= intr_pick;
    end
  end
  assign bus.order_code  = ord_r;
  assign bus.forced_addr = addr_r;
  assign bus.test_data   = tdata_r;
  assign bus.test_op     = top_r;
  assign test_busy       = (ord_r == psc_pkg::PSC_ORD_TEST);
endmodule

// ---- psc_pkg.sv ----
// package of constants for the priority start interrupt control
package psc_pkg;
  localparam int NUM_PULSES   = 12;          // time pulses per memory cycle
  localparam int NUM_VECTORS  = 10;          // interrupt vectors
  localparam int NUM_COUNTERS = 29;          // counter addresses
  localparam int ADDR_W       = 12;          // vector address width
  localparam int DATA_W       = 16;          // word width
  localparam logic [3:0]  FINAL_PULSE  = 4'hb;   // index of the final time pulse
  localparam logic [11:0] START_ADDR   = 12'h800; // start instruction address
  localparam logic [11:0] VEC_BASE     = 12'h800; // first interrupt vector
  localparam logic [11:0] VEC_STEP     = 12'h004; // spacing of vectors
  localparam logic [11:0] CNT_BASE     = 12'h024; // first counter address
  localparam int RESET_HOLD   = 4;           // time pulses start is held
  localparam int ALARM_CYCLES = 8;           // cycles a counter pulse may wait
  // forced order codes to the sequencer
  typedef enum logic [2:0] {
    PSC_ORD_NONE  = 3'h0,
    PSC_ORD_START = 3'h1,
    PSC_ORD_INTR  = 3'h2,
    PSC_ORD_CNT   = 3'h3,
    PSC_ORD_TEST  = 3'h4
  } psc_order_t;
  // tester operation kinds
  typedef enum logic [1:0] {
    PSC_TOP_READ  = 2'h0,
    PSC_TOP_LOAD  = 2'h1,
    PSC_TOP_GO    = 2'h2,
    PSC_TOP_NONE  = 2'h3
  } psc_top_t;
endpackage

// ---- psc_if.sv ----
// interface joining priority control and the sequencer side
`timescale 1ns/1ps
interface psc_if;
  logic [3:0]        time_pulse;     // current time pulse index
  logic              cycle_end;      // pulse at the final time pulse
  logic              tpg_stop;       // stop to the time pulse generator
  logic              fresh_start;    // initialization broadcast
  logic [2:0]        order_code;     // forced order code
  logic [11:0]       forced_addr;    // address on the write lines
  logic [15:0]       test_data;      // tester load data
  logic [1:0]        test_op;        // tester operation kind
  logic              read_pulse;     // sequencer read control pulse
  logic              start_done;     // start instruction forced
  logic [11:0]       decoded_addr;   // address returned from processor
  logic              addr_valid;     // decoded address valid
  logic              monitor_stop;   // monitor stop mode
  logic              program_run;    // a programmed instruction executes
  modport dev (
    output time_pulse, output cycle_end, output tpg_stop, output fresh_start,
    output order_code, output forced_addr, output test_data, output test_op,
    output monitor_stop,
    input read_pulse, input start_done, input decoded_addr, input addr_valid,
    input program_run
  );
  modport seq (
    input time_pulse, input cycle_end, input tpg_stop, input fresh_start,
    input order_code, input forced_addr, input test_data, input test_op,
    input monitor_stop,
    output read_pulse, output start_done, output decoded_addr, output addr_valid,
    output program_run
  );
endinterface

// ---- psc_timer.sv ----
// time pulse generator with stop and park
`timescale 1ns/1ps
module psc_timer (
  input  wire logic       clk,
  input  wire logic       nrst,
  input  wire logic       tick,
  input  wire logic       stop,
  output logic [3:0]      pulse,
  output logic            cycle_end
);
  logic [3:0] pulse_r; // current pulse index

  // step one pulse per tick, parked at final pulse while stopped
  always_ff @(posedge clk) begin
    if (!nrst) begin
      pulse_r <= psc_pkg::FINAL_PULSE;
    end else if (tick) begin
      if (pulse_r == psc_pkg::FINAL_PULSE) begin
        if (!stop) begin
          pulse_r <= 4'h0;
        end
      end else begin
        pulse_r <= pulse_r + 4'h1;
      end
    end
  end

  assign pulse     = pulse_r;
  // a stopped generator ends no cycle, so no word flow happens
  assign cycle_end = tick && !stop && (pulse_r == psc_pkg::FINAL_PULSE);
endmodule

// ---- psc_seq.sv ----
// sequencer end: takes forced orders and returns decoded addresses
`timescale 1ns/1ps
module psc_seq (
  input  wire logic        clk,
  input  wire logic        nrst,
  psc_if.seq               bus,
  input  wire logic        prog_want,
  output logic [2:0]       taken_order,
  output logic [11:0]      taken_addr,
  output logic             taken_valid
);
  logic pend_r; // read pulse already given for this order

  // one read pulse per forced order at the final time pulse
  always_ff @(posedge clk) begin
    if (!nrst) begin
      pend_r      <= 1'b0;
      taken_order <= '0;
      taken_addr  <= '0;
      taken_valid <= 1'b0;
    end else begin
      taken_valid <= 1'b0;
      if (bus.order_code == psc_pkg::PSC_ORD_NONE) begin
        pend_r <= 1'b0;
      end else if (!pend_r && bus.time_pulse == psc_pkg::FINAL_PULSE) begin
        pend_r      <= 1'b1;
        taken_order <= bus.order_code;
        taken_addr  <= bus.forced_addr;
        taken_valid <= 1'b1;
      end
    end
  end

  // read pulse when taking; address decoded straight back
  assign bus.read_pulse   = bus.order_code != psc_pkg::PSC_ORD_NONE && !pend_r
                            && bus.time_pulse == psc_pkg::FINAL_PULSE;
  assign bus.addr_valid   = bus.read_pulse;
  assign bus.decoded_addr = bus.forced_addr;
  assign bus.start_done   = bus.read_pulse && bus.order_code == psc_pkg::PSC_ORD_START;
  // programmed work yields to forced orders and stops
  assign bus.program_run  = prog_want && !bus.tpg_stop && !bus.monitor_stop
                            && bus.order_code == psc_pkg::PSC_ORD_NONE;
endmodule

// ---- psc_assertions.sv ----
// concurrent checks on the signals joining priority control and sequencer
`timescale 1ns/1ps
module psc_assertions (
  input wire logic        clk,
  input wire logic        nrst,
  input wire logic [3:0]  time_pulse,
  input wire logic        cycle_end,
  input wire logic        tpg_stop,
  input wire logic        fresh_start,
  input wire logic [2:0]  order_code,
  input wire logic [11:0] forced_addr,
  input wire logic        read_pulse,
  input wire logic        monitor_stop,
  input wire logic        program_run
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  // end of memory cycle only on the final pulse
  property p_cycle_end; cycle_end |-> time_pulse == psc_pkg::FINAL_PULSE; endproperty
  a_cycle_end: assert property (p_cycle_end) else $error("cycle end off final pulse");
  // fresh start never runs without the timer stop
  property p_fresh_stop; fresh_start |-> tpg_stop; endproperty
  a_fresh_stop: assert property (p_fresh_stop) else $error("fresh start without stop");
  // vector moves only on a read pulse at the final pulse
  property p_read_at; read_pulse |-> time_pulse == 4'hb && order_code != 3'h0; endproperty
  a_read_at: assert property (p_read_at) else $error("read pulse out of place");
  // order withdrawn once taken
  property p_clear; read_pulse |=> order_code == 3'h0; endproperty
  a_clear: assert property (p_clear) else $error("order not cleared");
  // order and address stand until read
  property p_stand; order_code != 3'h0 && !read_pulse |=> $stable(order_code) && $stable(forced_addr);
  endproperty
  a_stand: assert property (p_stand) else $error("order changed before read");
  // interrupt vectors are ten spaced slots
  property p_vec; order_code == psc_pkg::PSC_ORD_INTR |->
    forced_addr[1:0] == 2'h0 && forced_addr >= 12'h800 && forced_addr <= 12'h824; endproperty
  a_vec: assert property (p_vec) else $error("bad interrupt vector");
  // counter addresses within the 29 slots
  property p_cnt; order_code == psc_pkg::PSC_ORD_CNT |->
    forced_addr >= 12'h024 && forced_addr <= 12'h040; endproperty
  a_cnt: assert property (p_cnt) else $error("bad counter address");
  // start order carries the start address
  property p_start; order_code == psc_pkg::PSC_ORD_START |-> forced_addr == 12'h800; endproperty
  a_start: assert property (p_start) else $error("bad start address");
  // no programmed work while an order is forced
  property p_prog; order_code != 3'h0 |-> !program_run; endproperty
  a_prog: assert property (p_prog) else $error("program ran during forced order");
  // tester orders only in monitor stop
  property p_test; order_code == psc_pkg::PSC_ORD_TEST |-> monitor_stop; endproperty
  a_test: assert property (p_test) else $error("tester order outside monitor stop");
  // monitor stop parks the timer at the final pulse
  property p_park; monitor_stop && time_pulse == 4'hb |=> time_pulse == 4'hb; endproperty
  a_park: assert property (p_park) else $error("timer left final pulse");
  // main scenarios reached
  c_intr: cover property (read_pulse && order_code == psc_pkg::PSC_ORD_INTR);
  c_cnt: cover property (read_pulse && order_code == psc_pkg::PSC_ORD_CNT);
  c_test: cover property (read_pulse && order_code == psc_pkg::PSC_ORD_TEST);
  c_start: cover property (read_pulse && order_code == psc_pkg::PSC_ORD_START);
endmodule

// ---- tb.sv ----
// self-checking bench for both ends of the priority control link
`timescale 1ns/1ps
module tb;
  logic        clk = 1'b0;            // 125 MHz
  logic        nrst = 1'b0;           // sync reset
  logic        power_ok_pin = 1'b1;   // supply good
  logic        alarm_pin = 1'b0;      // alarm cause
  logic        trap_pin = 1'b0;       // program trap cause
  logic        intr_fault_pin = 1'b0; // interrupt fault cause
  logic        mon_stop_pin = 1'b0;   // monitor stop from tester
  logic        manual_start_pin = 1'b0;
  logic [9:0]  intr_req = 10'h000;    // interrupt requests
  logic [28:0] cnt_req = 29'h0;       // counter requests
  logic        test_req = 1'b0;       // tester order request
  logic [1:0]  test_kind = 2'h0;
  logic [11:0] test_addr = 12'h000;
  logic [15:0] test_wdata = 16'h0000;
  logic        prog_want = 1'b1;      // program always wants to run
  logic        test_busy, cnt_alarm, taken_valid;
  logic [9:0]  intr_pend;
  logic [2:0]  taken_order;
  logic [11:0] taken_addr;
  int          num_errors = 0;
  int          n_tests = 0;
  logic [2:0]  o;
  logic [11:0] a;
  psc_if bus_if();
  psc_ctrl #(.DIV(4)) i_psc_ctrl (.clk(clk), .nrst(nrst), .bus(bus_if),
    .power_ok_pin(power_ok_pin), .alarm_pin(alarm_pin), .trap_pin(trap_pin),
    .intr_fault_pin(intr_fault_pin), .mon_stop_pin(mon_stop_pin),
    .manual_start_pin(manual_start_pin), .intr_req(intr_req), .cnt_req(cnt_req),
    .test_req(test_req), .test_kind(test_kind), .test_addr(test_addr),
    .test_wdata(test_wdata), .test_busy(test_busy), .cnt_alarm(cnt_alarm),
    .intr_pend(intr_pend));
  psc_seq i_psc_seq (.clk(clk), .nrst(nrst), .bus(bus_if), .prog_want(prog_want),
    .taken_order(taken_order), .taken_addr(taken_addr), .taken_valid(taken_valid));
  psc_assertions i_psc_assertions (.clk(clk), .nrst(nrst), .time_pulse(bus_if.time_pulse),
    .cycle_end(bus_if.cycle_end), .tpg_stop(bus_if.tpg_stop),
    .fresh_start(bus_if.fresh_start), .order_code(bus_if.order_code),
    .forced_addr(bus_if.forced_addr), .read_pulse(bus_if.read_pulse),
    .monitor_stop(bus_if.monitor_stop), .program_run(bus_if.program_run));
  // clock
  always #4 clk = ~clk;
  // compare and count
  task automatic chk(input string n, input logic [15:0] s, input logic [15:0] e);
    n_tests++;
    if (s !== e) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask
  // wait, bounded, for the sequencer to take an order
  task automatic take(output logic [2:0] to, output logic [11:0] ta);
    int k;
    k = 0;
    do begin
      @(posedge clk);
      #1;
      k++;
    end while (taken_valid !== 1'b1 && k < 600);
    chk("taken in time", 16'(k < 600), 16'h0001);
    to = taken_order;
    ta = taken_addr;
  endtask
  // each vector in turn, pending cleared when taken
  task automatic t_intr();
    for (int i = 0; i < 10; i++) begin
      @(posedge clk) intr_req <= 10'(1 << i);
      @(posedge clk) intr_req <= 10'h000;
      take(o, a);
      chk("intr order", 16'(o), 16'h0002);
      chk("intr addr", 16'(a), 16'(12'h800 + 12'(4 * i)));
      chk("intr pend", 16'(intr_pend), 16'h0000);
    end
  endtask
  // counter before interrupts, lowest index first, others stay pending
  task automatic t_prio();
    @(posedge clk) begin
      intr_req <= 10'h022;
      cnt_req <= 29'h8;
    end
    @(posedge clk) begin
      intr_req <= 10'h000;
      cnt_req <= 29'h0;
    end
    take(o, a);
    chk("cnt first", 16'(o), 16'h0003);
    chk("cnt addr", 16'(a), 16'h0027);
    chk("still pend", 16'(intr_pend), 16'h0022);
    take(o, a);
    chk("low vector", 16'(a), 16'h0804);
    take(o, a);
    chk("high vector", 16'(a), 16'h0814);
    chk("no alarm", 16'(cnt_alarm), 16'h0000);
  endtask
  // every start cause stops the timer, broadcasts, then forces start
  task automatic t_faults();
    for (int c = 0; c < 5; c++) begin
      @(posedge clk) case (c)
        0: power_ok_pin <= 1'b0;
        1: alarm_pin <= 1'b1;
        2: trap_pin <= 1'b1;
        3: intr_fault_pin <= 1'b1;
        default: begin
          mon_stop_pin <= 1'b1;
          manual_start_pin <= 1'b1;
        end
      endcase
      repeat (10) @(posedge clk);
      #1;
      chk("fresh start", 16'(bus_if.fresh_start), 16'h0001);
      chk("timer stop", 16'(bus_if.tpg_stop), 16'h0001);
      @(posedge clk) begin
        power_ok_pin <= 1'b1;
        alarm_pin <= 1'b0;
        trap_pin <= 1'b0;
        intr_fault_pin <= 1'b0;
        mon_stop_pin <= 1'b0;
        manual_start_pin <= 1'b0;
      end
      take(o, a);
      chk("start order", 16'(o), 16'h0001);
      chk("start addr", 16'(a), 16'h0800);
      chk("fresh ends", 16'(bus_if.fresh_start), 16'h0000);
    end
  endtask
  // tester read, load and go, only under monitor stop
  task automatic t_test();
    @(posedge clk) mon_stop_pin <= 1'b1;
    repeat (100) @(posedge clk);
    #1;
    chk("parked", 16'(bus_if.time_pulse), 16'h000b);
    for (int k = 0; k < 3; k++) begin
      @(posedge clk) begin
        test_req <= 1'b1;
        test_kind <= 2'(k);
        test_addr <= 12'h123 + 12'(k);
        test_wdata <= 16'ha5a0 + 16'(k);
      end
      // one-cycle request, so an idle control takes it exactly once
      @(posedge clk) test_req <= 1'b0;
      #1;
      chk("test busy", 16'(test_busy), 16'h0001);
      chk("test op", 16'(bus_if.test_op), 16'(k));
      take(o, a);
      chk("test order", 16'(o), 16'h0004);
      chk("test addr", 16'(a), 16'(12'h123 + 12'(k)));
      chk("test data", bus_if.test_data, 16'ha5a0 + 16'(k));
      chk("test idle", 16'(test_busy), 16'h0000);
      repeat (20) @(posedge clk);
    end
    @(posedge clk) mon_stop_pin <= 1'b0;
  endtask
  // verdict and end of run
  task automatic conclude();
    if (num_errors == 0 && n_tests > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // main sequence
  initial begin
    repeat (20) @(posedge clk);
    nrst <= 1'b1;
    take(o, a);
    chk("reset start", 16'(o), 16'h0001);
    chk("reset addr", 16'(a), 16'h0800);
    t_intr();
    t_prio();
    t_faults();
    t_test();
    conclude();
  end
  // watchdog, about 50000 cycles
  initial begin
    #400000;
    num_errors++;
    conclude();
  end
endmodule
